// file: hdl/uart_wakeup_ctrl.sv
// Serial control block: registers, receiver sleep and wakeup, idle detection, pins, interrupt.
//
// How it works
// RULE1: Sleep forces every receiver flag, including rx active, to stay clear.
// RULE2: Hardware clears sleep when a new message starts; software may clear it.
// RULE3: Idle-line wakeup: a full frame of ones on the line wakes the receiver.
// RULE4: The sender leaves idle between messages and none within one.
// RULE5: Address-mark wakeup: a character with data MSB set wakes the receiver.
// RULE6: Idle count type 0 counts ones after start bit; 1 only after stop.
// RULE7: Short type lets trailing one bits of a character count as idle.
// RULE8: A 13-bit modulus divider, fed from the crystal clock, makes bit ticks.
// RULE9: Bit rate is crystal clock over 32 over the divisor.
// RULE10: The divisor may be rewritten at any time and takes effect.
// RULE11: Baud test and split bits are reachable only in special test mode.
// RULE12: Loopback feeds transmitter into receiver, holds transmit pin high.
// RULE13: Open-drain select makes the transmit pin drive low only.
// RULE14: Word size bit picks eight or nine data bits per frame.
// RULE15: Wakeup method bit picks idle line (0) or address mark (1).
// RULE16: Parity enabled is checked; odd select flips the expected sense.
// RULE17: Tx empty enable requests the interrupt while tx empty is set.
// RULE18: Tx done enable requests the interrupt while tx done is set.
// RULE19: Rx enable requests the interrupt while rx full or overrun is set.
// RULE20: Idle enable requests the interrupt while the idle flag is set.
// RULE21: Frame is start 0, data LSB first, stop 1.
// RULE22: Status read with flag set, then data access, clears that flag.
// RULE23: All enabled sources merge into one interrupt request line.
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module uart_wakeup_ctrl
    import uart_wake_pkg::*;
(
    input  wire logic                          mclk,
    input  wire logic                          nrst,
    input  wire logic [uart_wake_pkg::ADDR_W-1:0] addr,
    input  wire logic [uart_wake_pkg::DATA_W-1:0] wdata,
    input  wire logic                          wr_stb,
    input  wire logic                          rd_stb,
    output logic      [uart_wake_pkg::DATA_W-1:0] rdata,
    input  wire logic                          test_mode,
    input  wire logic                          rxd_in,
    output logic                               txd_out,
    output logic                               txd_oe,
    input  wire logic                          tx_serial,
    input  wire logic                          tx_empty_set,
    input  wire logic                          tx_done_set,
    input  wire logic                          rx_noise_set,
    output logic      [8:0]                    tx_word,
    output logic                               tx_load,
    output logic                               tx_on,
    output logic                               rx_on,
    output logic                               bit_tick,
    output logic                               irq
);
    import uart_wake_pkg::*;

    typedef enum logic [1:0] {RX_IDLE, RX_DATA, RX_STOP} rx_state_e;

    logic [7:0]        baud_high_reg;
    logic [7:0]        baud_low_reg;
    logic [7:0]        ctrl_one_reg;
    logic [7:0]        ctrl_two_reg;
    logic [NFLAGS-1:0] flag_reg;
    logic [NFLAGS-1:0] flag_set;
    logic [NFLAGS-1:0] flag_clr;
    logic [NFLAGS-1:0] armed_reg;
    logic [8:0]        rx_word_reg;
    logic [8:0]        shift_reg;
    logic [3:0]        bit_cnt_reg;
    logic [3:0]        ones_cnt_reg;
    logic              line_active_reg;
    logic              par_acc_reg;
    rx_state_e         rx_state_reg;
    logic              rx_line;
    logic              rx_run;
    logic              word9;
    logic              wake_method;
    logic              rx_sleep;
    logic              char_done;
    logic              stop_ok;
    logic              parity_bad;
    logic              word_msb;
    logic              idle_event;
    logic              wake_now;
    logic              sleep_eff;
    logic              rx_active;
    logic              count_one;
    logic [3:0]        data_bits;
    logic [3:0]        frame_len;
    logic [8:0]        assembled;
    logic              wr_hit_ctrl2;
    logic              data_access;

    assign word9       = ctrl_one_reg[C1_WORD9];
    assign wake_method = ctrl_one_reg[C1_WAKE];
    assign rx_sleep    = ctrl_two_reg[C2_SLP];
    assign tx_on       = ctrl_two_reg[C2_TXON];
    assign rx_on       = ctrl_two_reg[C2_RXON];
    assign data_bits   = word9 ? DATA_BITS9 : DATA_BITS8; // RULE14
    assign frame_len   = word9 ? FRAME_LEN9 : FRAME_LEN8; // RULE14
    assign wr_hit_ctrl2 = wr_stb && addr == OFF_CTRL_TWO;
    assign data_access  = (rd_stb || wr_stb) && addr == OFF_DATA_LOW;

    baud_tick_gen #(
        .DW       (DIV_W)
    ) u_baud (
        .mclk     (mclk),
        .nrst     (nrst),
        .divisor  ({baud_high_reg[BH_DIV_W-1:0], baud_low_reg}),
        .bit_tick (bit_tick)
    );

    // Loopback takes the receiver off the pin; it needs both directions on to run.
    assign rx_line = ctrl_one_reg[C1_LOOP] ? tx_serial : rxd_in; // RULE12
    assign rx_run  = rx_on && (!ctrl_one_reg[C1_LOOP] || tx_on); // RULE12

    // Transmit pin: idle high in loopback; open drain only ever pulls low.
    always_comb
    begin
        txd_out = ctrl_one_reg[C1_LOOP] ? 1'b1 : tx_serial; // RULE12
        if (!tx_on)
            txd_oe = 1'b0;
        else if (ctrl_one_reg[C1_ODRAIN])
            txd_oe = !txd_out; // RULE13
        else
            txd_oe = 1'b1;
    end

    // Baud registers; the two factory bits change only in test mode.
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            baud_high_reg <= {3'h0, DIV_RESET[12:8]};
            baud_low_reg  <= DIV_RESET[7:0];
        end
        else if (wr_stb)
        begin
            if (addr == OFF_BAUD_HIGH)
            begin
                baud_high_reg[BH_DIV_W-1:0] <= wdata[BH_DIV_W-1:0]; // RULE10
                if (test_mode)
                begin
                    baud_high_reg[BH_TEST]  <= wdata[BH_TEST]; // RULE11
                    baud_high_reg[BH_SPLIT] <= wdata[BH_SPLIT]; // RULE11
                end
            end
            if (addr == OFF_BAUD_LOW)
                baud_low_reg <= wdata; // RULE10
        end
    end

    // Control one holds the frame, wakeup, idle type, parity and pin options.
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            ctrl_one_reg <= CTRL_RESET;
        else if (wr_stb && addr == OFF_CTRL_ONE)
            ctrl_one_reg <= {wdata[7:6], 1'b0, wdata[4:0]};
    end

    // Software write wins over a hardware wake in the same cycle, it is the later intent.
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            ctrl_two_reg <= CTRL_RESET;
        else if (wr_hit_ctrl2)
            ctrl_two_reg <= {wdata[7:1], 1'b0}; // RULE2
        else if (wake_now)
            ctrl_two_reg[C2_SLP] <= 1'b0; // RULE2
    end

    // Receive frame tracker, one sample per bit tick.
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            rx_state_reg <= RX_IDLE;
            bit_cnt_reg  <= '0;
            shift_reg    <= '0;
            par_acc_reg  <= 1'b0;
        end
        else if (!rx_run)
            rx_state_reg <= RX_IDLE;
        else if (bit_tick)
        begin
            case (rx_state_reg)
                RX_IDLE:
                begin
                    if (!rx_line) // RULE21
                    begin
                        rx_state_reg <= RX_DATA;
                        bit_cnt_reg  <= '0;
                        par_acc_reg  <= 1'b0;
                    end
                end
                RX_DATA:
                begin
                    shift_reg   <= {rx_line, shift_reg[8:1]}; // RULE21
                    par_acc_reg <= par_acc_reg ^ rx_line;
                    bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    if (bit_cnt_reg == data_bits - 4'h1)
                        rx_state_reg <= RX_STOP;
                end
                RX_STOP:
                    rx_state_reg <= RX_IDLE;
                default:
                    rx_state_reg <= RX_IDLE;
            endcase
        end
    end

    assign char_done = rx_run && bit_tick && rx_state_reg == RX_STOP;
    assign stop_ok   = rx_line; // RULE21
    assign assembled = word9 ? shift_reg : {1'b0, shift_reg[8:1]};
    assign word_msb  = word9 ? assembled[8] : assembled[7];
    // Parity bit is the top data bit, so the whole word's ones count is checked.
    assign parity_bad = ctrl_one_reg[C1_PEN] && (par_acc_reg != ctrl_one_reg[C1_PODD]); // RULE16

    // Short type counts from after the start bit, long type only once idle.
    assign count_one = ctrl_one_reg[C1_ILT] ? (rx_state_reg == RX_IDLE) // RULE6
                                            : (rx_state_reg != RX_IDLE || rx_line); // RULE6 RULE7

    // Idle counter; trailing ones of a character already count in short mode.
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            ones_cnt_reg    <= '0;
            line_active_reg <= 1'b0;
        end
        else if (!rx_run)
        begin
            ones_cnt_reg    <= '0;
            line_active_reg <= 1'b0;
        end
        else if (bit_tick)
        begin
            if (!rx_line)
            begin
                ones_cnt_reg    <= '0;
                line_active_reg <= 1'b1;
            end
            else if (idle_event)
            begin
                ones_cnt_reg    <= '0;
                line_active_reg <= 1'b0;
            end
            else if (count_one && ones_cnt_reg != frame_len)
                ones_cnt_reg <= ones_cnt_reg + 4'h1; // RULE7
        end
    end

    // Idle fires once per active-to-idle change, so a quiet line does not repeat it.
    assign idle_event = rx_run && bit_tick && rx_line && count_one && line_active_reg
                        && ones_cnt_reg == frame_len - 4'h1; // RULE3

    // The waking event itself is let through so software sees the address or idle.
    assign wake_now  = rx_sleep && (wake_method ? (char_done && word_msb) // RULE5 RULE15
                                                : idle_event); // RULE3 RULE15
    assign sleep_eff = rx_sleep && !wake_now; // RULE1
    assign rx_active = rx_run && !rx_sleep && rx_state_reg != RX_IDLE; // RULE1

    // Event sources for the sticky flags, all receiver ones gated by sleep.
    always_comb
    begin
        flag_set         = '0;
        flag_set[F_TXE]  = tx_empty_set;
        flag_set[F_TXD]  = tx_done_set;
        flag_set[F_FULL] = !sleep_eff && char_done && !flag_reg[F_FULL]; // RULE1
        flag_set[F_OVR]  = !sleep_eff && char_done && flag_reg[F_FULL]; // RULE1
        flag_set[F_FRM]  = !sleep_eff && char_done && !flag_reg[F_FULL] && !stop_ok;
        flag_set[F_PAR]  = !sleep_eff && char_done && !flag_reg[F_FULL] && parity_bad;
        flag_set[F_IDLE] = !sleep_eff && idle_event; // RULE1
        flag_set[F_NOIS] = !sleep_eff && rx_noise_set; // RULE1
        flag_clr         = data_access ? armed_reg : '0; // RULE22
    end

    // A status read arms exactly the flags it saw set.
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            armed_reg <= '0;
        else if (rd_stb && addr == OFF_STATUS1)
            armed_reg <= flag_reg; // RULE22
        else if (data_access)
            armed_reg <= '0;
    end

    // Flags: a set in the clearing cycle is kept.
    genvar gi;
    generate
        for (gi = 0; gi < NFLAGS; gi++)
        begin : g_flag
            always_ff @(posedge mclk or negedge nrst)
            begin
                if (!nrst)
                    flag_reg[gi] <= 1'b0;
                else
                    flag_reg[gi] <= flag_set[gi] | (flag_reg[gi] & ~flag_clr[gi]); // RULE22
            end
        end
    endgenerate

    // Received word is held until the next character that finds the buffer empty.
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            rx_word_reg <= '0;
        else if (flag_set[F_FULL])
            rx_word_reg <= assembled;
    end

    // Writes to the data pair hand the word to the transmit path.
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            tx_word <= '0;
            tx_load <= 1'b0;
        end
        else
        begin
            tx_load <= wr_stb && addr == OFF_DATA_LOW;
            if (wr_stb && addr == OFF_DATA_HIGH)
                tx_word[8] <= wdata[0];
            if (wr_stb && addr == OFF_DATA_LOW)
                tx_word[7:0] <= wdata;
        end
    end

    // Read data stand in the cycle after the strobe; unmapped reads return zero.
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            rdata <= '0;
        else if (rd_stb)
        begin
            case (addr)
                OFF_BAUD_HIGH: rdata <= test_mode ? baud_high_reg
                                                  : {3'h0, baud_high_reg[BH_DIV_W-1:0]}; // RULE11
                OFF_BAUD_LOW:  rdata <= baud_low_reg;
                OFF_CTRL_ONE:  rdata <= ctrl_one_reg;
                OFF_CTRL_TWO:  rdata <= ctrl_two_reg;
                OFF_STATUS1:   rdata <= flag_reg;
                OFF_STATUS2:   rdata <= {7'h00, rx_active};
                OFF_DATA_HIGH: rdata <= {7'h00, rx_word_reg[8]};
                OFF_DATA_LOW:  rdata <= rx_word_reg[7:0];
                default:       rdata <= '0;
            endcase
        end
        else
            rdata <= '0;
    end

    // One request line for all enabled sources.
    assign irq = (ctrl_two_reg[C2_TIE] && flag_reg[F_TXE]) // RULE17 RULE23
              || (ctrl_two_reg[C2_TX_DONE_IRQ_EN] && flag_reg[F_TXD]) // RULE18
              || (ctrl_two_reg[C2_RIE] && (flag_reg[F_FULL] || flag_reg[F_OVR])) // RULE19
              || (ctrl_two_reg[C2_IDLE_IRQ_EN] && flag_reg[F_IDLE]); // RULE20

    sequence s_status_seen;
        rd_stb && addr == OFF_STATUS1 && flag_reg[F_FULL];
    endsequence
    sequence s_data_read;
        rd_stb && addr == OFF_DATA_LOW && !char_done;
    endsequence

    property p_sleep_quiet;
        @(posedge mclk) disable iff (!nrst)
        rx_sleep |-> !rx_active;
    endproperty
    a_sleep_quiet: assert property (p_sleep_quiet) // RULE1
        else $error("Receiver shows activity while asleep.");

    property p_sleep_no_full;
        @(posedge mclk) disable iff (!nrst)
        (rx_sleep && !wake_now && !flag_reg[F_FULL]) |=> !flag_reg[F_FULL];
    endproperty
    a_sleep_no_full: assert property (p_sleep_no_full) // RULE1
        else $error("Rx full flag set while asleep.");

    property p_idle_wake;
        @(posedge mclk) disable iff (!nrst)
        (idle_event && !wake_method && rx_sleep && !wr_hit_ctrl2) |=> !rx_sleep;
    endproperty
    a_idle_wake: assert property (p_idle_wake) // RULE3
        else $error("Idle line did not wake the receiver.");

    property p_addr_wake;
        @(posedge mclk) disable iff (!nrst)
        (char_done && wake_method && word_msb && rx_sleep && !wr_hit_ctrl2) |=> !rx_sleep;
    endproperty
    a_addr_wake: assert property (p_addr_wake) // RULE5
        else $error("Address character did not wake the receiver.");

    property p_loop_high;
        @(posedge mclk) disable iff (!nrst)
        ctrl_one_reg[C1_LOOP] |-> txd_out;
    endproperty
    a_loop_high: assert property (p_loop_high) // RULE12
        else $error("Transmit pin not held high in loopback.");

    property p_odrain;
        @(posedge mclk) disable iff (!nrst)
        (ctrl_one_reg[C1_ODRAIN] && txd_oe) |-> !txd_out;
    endproperty
    a_odrain: assert property (p_odrain) // RULE13
        else $error("Open-drain pin driven high.");

    property p_test_bits;
        @(posedge mclk) disable iff (!nrst)
        !test_mode |=> $stable(baud_high_reg[BH_TEST:BH_SPLIT]);
    endproperty
    a_test_bits: assert property (p_test_bits) // RULE11
        else $error("Factory baud bits changed outside test mode.");

    property p_clear_seq;
        @(posedge mclk) disable iff (!nrst)
        s_status_seen ##1 s_data_read |=> !flag_reg[F_FULL];
    endproperty
    a_clear_seq: assert property (p_clear_seq) // RULE22
        else $error("Rx full not cleared by status then data read.");

    property p_rx_irq;
        @(posedge mclk) disable iff (!nrst)
        (ctrl_two_reg[C2_RIE] && $rose(flag_reg[F_OVR])) |-> irq;
    endproperty
    a_rx_irq: assert property (p_rx_irq) // RULE19
        else $error("Overrun with receive enable gave no interrupt.");
endmodule : uart_wakeup_ctrl
`default_nettype wire

// file: hdl/uart_wake_pkg.sv
// Shared constants for the serial wakeup, baud and control block.
package uart_wake_pkg;
    // Register bus geometry.
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] OFF_BAUD_HIGH = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_BAUD_LOW  = 4'h1;
    localparam logic [ADDR_W-1:0] OFF_CTRL_ONE  = 4'h2;
    localparam logic [ADDR_W-1:0] OFF_CTRL_TWO  = 4'h3;
    localparam logic [ADDR_W-1:0] OFF_STATUS1   = 4'h4;
    localparam logic [ADDR_W-1:0] OFF_STATUS2   = 4'h5;
    localparam logic [ADDR_W-1:0] OFF_DATA_HIGH = 4'h6;
    localparam logic [ADDR_W-1:0] OFF_DATA_LOW  = 4'h7;
    // Baud high register fields.
    localparam int BH_TEST  = 7;
    localparam int BH_SPLIT = 6;
    localparam int BH_DIV_W = 5;
    // Control one fields.
    localparam int C1_LOOP   = 7;
    localparam int C1_ODRAIN = 6;
    localparam int C1_WORD9  = 4;
    localparam int C1_WAKE   = 3;
    localparam int C1_ILT    = 2;
    localparam int C1_PEN    = 1;
    localparam int C1_PODD   = 0;
    // Control two fields.
    localparam int C2_TIE  = 7;
    localparam int C2_TX_DONE_IRQ_EN = 6;
    localparam int C2_RIE  = 5;
    localparam int C2_IDLE_IRQ_EN = 4;
    localparam int C2_TXON = 3;
    localparam int C2_RXON = 2;
    localparam int C2_SLP  = 1;
    // Status one flag positions, also the index into the flag vector.
    localparam int F_TXE  = 7;
    localparam int F_TXD  = 6;
    localparam int F_FULL = 5;
    localparam int F_IDLE = 4;
    localparam int F_OVR  = 3;
    localparam int F_NOIS = 2;
    localparam int F_FRM  = 1;
    localparam int F_PAR  = 0;
    localparam int NFLAGS = 8;
    localparam int S2_ACT = 0;
    // Divider and frame figures.
    localparam int          DIV_W      = 13;
    localparam int          PRESCALE   = 32;
    localparam logic [3:0]  DATA_BITS8 = 4'h8;
    localparam logic [3:0]  DATA_BITS9 = 4'h9;
    localparam logic [3:0]  FRAME_LEN8 = 4'hA;
    localparam logic [3:0]  FRAME_LEN9 = 4'hB;
    localparam logic [7:0]  CTRL_RESET = 8'h00;
    localparam logic [12:0] DIV_RESET  = 13'h0004;
endpackage : uart_wake_pkg

// file: hdl/baud_tick_gen.sv
// Baud tick divider: fixed divide by 32 followed by a programmable modulus.
`timescale 1ns/1ps
`default_nettype none
module baud_tick_gen
    import uart_wake_pkg::*;
#(
    parameter int DW = DIV_W
)(
    input  wire logic          mclk,
    input  wire logic          nrst,
    input  wire logic [DW-1:0] divisor,
    output logic               bit_tick
);
    logic [4:0]    pre_reg;
    logic [DW-1:0] mod_reg;
    logic          pre_wrap;

    // The prescaler wraps every 32 cycles of the crystal clock.
    assign pre_wrap = (pre_reg == 5'(PRESCALE - 1));

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            pre_reg <= '0;
        else
            pre_reg <= pre_wrap ? 5'h00 : pre_reg + 5'h01; // RULE9
    end

    // Comparing with >= lets a smaller divisor written mid-count take effect at once.
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            mod_reg  <= '0;
            bit_tick <= 1'b0;
        end
        else
        begin
            bit_tick <= 1'b0;
            if (pre_wrap && divisor != '0)
            begin
                if (mod_reg >= divisor - DW'(1)) // RULE8 RULE10
                begin
                    mod_reg  <= '0;
                    bit_tick <= 1'b1;
                end
                else
                    mod_reg <= mod_reg + DW'(1);
            end
        end
    end

    property p_tick_gap;
        @(posedge mclk) disable iff (!nrst)
        bit_tick |=> !bit_tick [*8];
    endproperty
    a_tick_gap: assert property (p_tick_gap) // RULE9
        else $error("Bit ticks closer than the prescaler allows.");
endmodule : baud_tick_gen
`default_nettype wire

// file: tb/serial_node.sv
// Far serial node that puts asynchronous frames on the receive line.
`timescale 1ns/1ps
`default_nettype none
module serial_node
(
    input  wire logic mclk,
    input  wire logic bit_tick,
    output logic      line
);
    int i;

    // The line rests at logic 1 between frames.
    initial line = 1'b1;

    // One bit per tick: start 0, data LSB first, stop 1. Returns once stop is sampled.
    task automatic send(input logic [8:0] w, input int n);
        @(posedge mclk iff bit_tick);
        line <= 1'b0;
        for (i = 0; i < n; i++)
        begin
            @(posedge mclk iff bit_tick);
            line <= w[i];
        end
        @(posedge mclk iff bit_tick);
        line <= 1'b1;
        @(posedge mclk iff bit_tick);
        repeat (2) @(posedge mclk);
    endtask : send
endmodule : serial_node
`default_nettype wire

// file: tb/uart_wakeup_ctrl_bench.sv
// Bench for the serial control block: registers, baud, receive, sleep, pins, interrupt.
`timescale 1ns/1ps
`default_nettype none
module uart_wakeup_ctrl_bench;
    import uart_wake_pkg::*;
    logic       mclk, nrst, wr_stb, rd_stb, test_mode, tx_serial;
    logic       te_set, td_set, rxd, txd_out, txd_oe, bit_tick, irq, ns, ton, ron;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, v, w;
    int         mismatches, samples_checked, c, k;

    uart_wakeup_ctrl dut (.mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .test_mode(test_mode),
        .rxd_in(rxd), .txd_out(txd_out), .txd_oe(txd_oe), .tx_serial(tx_serial),
        .tx_empty_set(te_set), .tx_done_set(td_set), .rx_noise_set(ns),
        .tx_word(), .tx_load(), .tx_on(ton), .rx_on(ron), .bit_tick(bit_tick), .irq(irq));
    serial_node far (.mclk(mclk), .bit_tick(bit_tick), .line(rxd));

    // Free-running clock, 25 ns period.
    initial mclk = 1'b0;
    always #12.5 mclk = ~mclk;

    task automatic end_of_test;
        if (mismatches == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test

    task automatic chk(input string n, input logic [8:0] s, input logic [8:0] e);
        samples_checked++;
        if (s !== e)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr   <= a;
        wdata  <= d;
        wr_stb <= 1'b1;
        @(posedge mclk);
        wr_stb <= 1'b0;
    endtask : wr

    // Read data stands only in the cycle after the strobe, so it is taken mid-cycle.
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge mclk);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge mclk);
        rd_stb <= 1'b0;
        @(negedge mclk);
        d = rdata;
    endtask : rd

    // Status then data with no gap.
    task automatic rd2(input logic [3:0] a, input logic [3:0] b,
                       output logic [7:0] d, output logic [7:0] e);
        @(posedge mclk);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge mclk);
        addr   <= b;
        @(negedge mclk);
        d = rdata;
        @(posedge mclk);
        rd_stb <= 1'b0;
        @(negedge mclk);
        e = rdata;
    endtask : rd2

    task automatic rchk(input logic [3:0] a, input logic [7:0] e, input string n);
        rd(a, v);
        chk(n, {1'b0, v}, {1'b0, e});
    endtask : rchk

    // Cycles between two consecutive bit ticks.
    task automatic per(output int n);
        @(posedge mclk iff bit_tick);
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end while (bit_tick !== 1'b1);
    endtask : per

    // A hang is cut short well beyond the expected run of some 4000 cycles.
    initial
    begin
        #1000000;
        mismatches++;
        end_of_test();
    end

    initial
    begin
        {nrst, wr_stb, rd_stb, test_mode, tx_serial, te_set, td_set, ns} = 8'h00;
        addr = 4'h0;
        wdata = 8'h00;
        mismatches = 0;
        samples_checked = 0;
        repeat (12) @(posedge mclk);
        nrst <= 1'b1;
        rchk(OFF_BAUD_LOW, 8'h04, "baud_low");
        rchk(OFF_CTRL_TWO, 8'h00, "ctrl_two");
        rchk(4'hA, 8'h00, "unmapped");
        wr(OFF_BAUD_HIGH, 8'hFF);
        rchk(OFF_BAUD_HIGH, 8'h1F, "baud_high");
        test_mode <= 1'b1;
        wr(OFF_BAUD_HIGH, 8'hC0);
        rchk(OFF_BAUD_HIGH, 8'hC0, "baud_high_test");
        wr(OFF_BAUD_HIGH, 8'h00);
        test_mode <= 1'b0;
        // Divisor rewritten on the fly; after each change one interval is measured, one skipped, and the third is checked.
        wr(OFF_BAUD_LOW, 8'h02);
        per(c);
        per(c);
        chk("period2", 9'(c), 9'h040);
        wr(OFF_BAUD_LOW, 8'h01);
        per(c);
        per(c);
        chk("period1", 9'(c), 9'h020);
        wr(OFF_CTRL_TWO, 8'h24);
        far.send(9'h0A5, 8);
        far.send(9'h03C, 8);
        @(negedge mclk);
        chk("irq_rx", 9'(irq), 9'h001);
        rd2(OFF_STATUS1, OFF_DATA_LOW, v, w);
        chk("rx_full_ovr", {7'h00, v[F_FULL], v[F_OVR]}, 9'h003);
        chk("data8", {1'b0, w}, 9'h0A5);
        rd(OFF_STATUS1, v);
        chk("rx_full_clr", 9'(v[F_FULL]), 9'h000);
        // Data 03 has even ones below its top bit, which carries the parity.
        for (k = 0; k < 2; k++)
        begin
            wr(OFF_CTRL_ONE, 8'h02 | 8'(k));
            far.send(9'h003, 8);
            rd(OFF_STATUS1, v);
            chk("parity", 9'(v[F_PAR]), 9'(k));
            rd(OFF_DATA_LOW, v);
        end
        wr(OFF_CTRL_ONE, 8'h10);
        wr(OFF_CTRL_TWO, 8'h14);
        far.send(9'h155, 9);
        rd(OFF_STATUS1, v);
        rchk(OFF_DATA_HIGH, 8'h01, "data_high");
        rchk(OFF_DATA_LOW, 8'h55, "data9");
        repeat (12) @(posedge mclk iff bit_tick);
        @(negedge mclk);
        chk("irq_idle", 9'(irq), 9'h001);
        rd(OFF_STATUS1, v);
        rd(OFF_DATA_LOW, v);
        // Address-mark sleep: a data character is hidden, an address one wakes.
        wr(OFF_CTRL_ONE, 8'h08);
        wr(OFF_CTRL_TWO, 8'h06);
        ns <= 1'b1;
        @(posedge mclk);
        ns <= 1'b0;
        far.send(9'h012, 8);
        rd(OFF_STATUS1, v);
        chk("sleep_flags", {7'h00, v[F_FULL], v[F_NOIS]}, 9'h000);
        rchk(OFF_CTRL_TWO, 8'h06, "still_asleep");
        far.send(9'h081, 8);
        rchk(OFF_CTRL_TWO, 8'h04, "woke_addr");
        rchk(OFF_DATA_LOW, 8'h81, "addr_char");
        wr(OFF_CTRL_ONE, 8'h00);
        wr(OFF_CTRL_TWO, 8'h06);
        far.send(9'h0FF, 8);
        repeat (12) @(posedge mclk iff bit_tick);
        rchk(OFF_CTRL_TWO, 8'h04, "woke_idle");
        // Each transmit source raises the line under its own enable; status then data clears it.
        for (k = 0; k < 2; k++)
        begin
            wr(OFF_CTRL_TWO, 8'h80 >> k);
            te_set <= (k == 0);
            td_set <= (k == 1);
            @(posedge mclk);
            {te_set, td_set} <= 2'b00;
            repeat (2) @(negedge mclk);
            chk("irq_tx", 9'(irq), 9'h001);
            rd(OFF_STATUS1, v);
            wr(OFF_DATA_LOW, 8'h00);
            @(negedge mclk);
            chk("irq_clr", 9'(irq), 9'h000);
        end
        wr(OFF_CTRL_TWO, 8'h0C);
        wr(OFF_CTRL_ONE, 8'h80);
        @(negedge mclk);
        chk("pin_loop", {5'h00, ton, ron, txd_oe, txd_out}, 9'h00F);
        wr(OFF_CTRL_ONE, 8'h40);
        @(negedge mclk);
        chk("pin_od_low", {7'h00, txd_oe, txd_out}, 9'h002);
        tx_serial <= 1'b1;
        @(negedge mclk);
        chk("pin_od_high", 9'(txd_oe), 9'h000);
        end_of_test();
    end
endmodule : uart_wakeup_ctrl_bench
`default_nettype wire
